// ### logic/reset_cause_defines.vh
/*
 Constants for the reset-cause status block: register offsets, flag bit
 positions, reset values and timing counts.
 Assumes it is included by its bare name from the logic folder.
*/
`ifndef RESET_CAUSE_DEFINES_VH
`define RESET_CAUSE_DEFINES_VH

// ****************************************************************
// Register offsets (byte addresses on APB)
// ****************************************************************
`define OFS_CAUSE_FLAGS 12'h000
`define OFS_IRQ_MASK    12'h004
`define OFS_OPTIONS     12'h008
`define OFS_IRQ_STATUS  12'h00C

// ****************************************************************
// Flag bit positions in the cause register
// ****************************************************************
`define BIT_POWER_ON    1
`define BIT_EXT_LINE    2
`define BIT_WATCHDOG    3
`define BIT_BAD_OPCODE  4
`define BIT_BAD_FETCH   5
`define BIT_DEBUG_ENTRY 6
`define BIT_BROWNOUT    7

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define RST_CAUSE_FLAGS 8'h02
`define RST_IRQ_MASK    8'h00
`define RST_OPTIONS     8'h00
`define ERASED_BYTE     8'hFF

// ****************************************************************
// Timing: stretch of the external reset line drive
// ****************************************************************
`define LINE_DRIVE_NS     320
`define CLK_PERIOD_NS     5
`define LINE_DRIVE_CYCLES ((`LINE_DRIVE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### logic/reset_cause_status_register.v
/*
 Reset-cause status register with APB slave, interrupt status and mask,
 and the internal reset request logic that drives the external reset line.
 Assumes pclk at 200 MHz, presetn async active low, event inputs from
 other clock domains or pins, and a pad outside that resolves the line.
*/
// Behaviour
// (R1) Every software read of the cause register clears all its flags except any set in the same cycle.
// (R2) Power-on sets its own flag and clears every other flag not set in the same cycle.
// (R3) Other resets set only their own flag and keep the rest.
// (R4) Several flags may be set together.
// (R5) Power-on flag reads one after power-on, zero after a read.
// (R6) External line flag set by line reset, cleared by power-on or read.
// (R7) Watchdog flag set by watchdog timeout, cleared by power-on or read.
// (R8) Bad opcode flag set by illegal instruction, cleared by power-on or read.
// (R9) Bad fetch flag set by opcode fetch at unmapped address.
// (R10) Debug entry flag set when vectors erased and no test voltage.
// (R11) Brownout flag set by low-voltage inhibit, cleared by power-on or read.
// (R12) Every internal reset source drives the external reset line low.
// (R13) Unmapped data reads never cause reset or set the bad fetch flag.
// (R14) With stop disabled, a stop instruction counts as illegal opcode.
// (R15) Writes to the cause register leave its flags untouched.
`timescale 1ns/1ps
`include "reset_cause_defines.vh"

module reset_cause_status_register #(
   parameter LINE_CYCLES = `LINE_DRIVE_CYCLES
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        clk_en,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        power_on_event,
   input  wire        ext_reset_n_in,
   input  wire        watchdog_timeout,
   input  wire        illegal_opcode,
   input  wire        stop_executed,
   input  wire        unmapped_access,
   input  wire        opcode_fetch,
   input  wire        debug_entry_request,
   input  wire        vector_high_byte_7,
   input  wire [7:0]  vector_high_byte,
   input  wire [7:0]  vector_low_byte,
   input  wire        irq_at_test_voltage,
   input  wire        brownout_event,
   output wire        ext_reset_n_out,
   output wire        ext_reset_n_oe,
   output wire        internal_reset_req,
   output wire        irq
);

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************

   localparam NSYNC = 9;

   // Two-stage synchronisers for all pin and foreign-domain inputs.
   reg [NSYNC-1:0] sync_a;
   reg [NSYNC-1:0] sync_b;
   wire [NSYNC-1:0] raw_in = {power_on_event, ~ext_reset_n_in, watchdog_timeout, illegal_opcode,
                              stop_executed, unmapped_access & opcode_fetch, debug_entry_request,
                              irq_at_test_voltage, brownout_event};

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_a <= {NSYNC{1'b0}};
         sync_b <= {NSYNC{1'b0}};
      end else if (clk_en) begin
         sync_a <= raw_in;
         sync_b <= sync_a;
      end
   end

   // Vector bytes are static after power-on; sampled through two stages too.
   reg [15:0] vec_a;
   reg [15:0] vec_b;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vec_a <= 16'h0000;
         vec_b <= 16'h0000;
      end else if (clk_en) begin
         vec_a <= {vector_high_byte, vector_low_byte};
         vec_b <= vec_a;
      end
   end

   // Synchronised levels; rising edges mark one reset event each.
   wire s_por    = sync_b[8];
   wire s_line   = sync_b[7];
   wire s_wdog   = sync_b[6];
   wire s_bad_opcode_flag   = sync_b[5];
   wire s_stop   = sync_b[4];
   wire s_fetch  = sync_b[3];
   wire s_dbg    = sync_b[2];
   wire s_vtst   = sync_b[1];
   wire s_brown  = sync_b[0];

   // ****************************************************************
   // Option register and event decode
   // ****************************************************************

   reg [7:0] options;
   reg [7:0] irq_mask;
   reg [7:0] prev_ev;

   // Line drive state, declared here because the event decode masks with it.
   reg        line_drive;
   reg [1:0]  drive_tail;

   // Our own drive returns through the line synchroniser two cycles late,
   // so the mask is stretched by two cycles to keep it out of the line flag.
   wire       own_drive = line_drive | (|drive_tail);

   wire stop_enable = options[0];

   // Opcode fetch only: unmapped data reads are not qualified.
   wire ev_fetch = s_fetch; // R13
   wire ev_bad_opcode_flag  = s_bad_opcode_flag | (s_stop & ~stop_enable); // R14
   wire vec_erased = (vec_b[15:8] == `ERASED_BYTE) && (vec_b[7:0] == `ERASED_BYTE);
   wire ev_dbg   = s_dbg & vec_erased & ~s_vtst; // R10

   wire [7:0] ev_level;
   assign ev_level[0]                = 1'b0;
   assign ev_level[`BIT_POWER_ON]    = s_por;
   assign ev_level[`BIT_EXT_LINE]    = s_line & ~own_drive; // R6
   assign ev_level[`BIT_WATCHDOG]    = s_wdog;
   assign ev_level[`BIT_BAD_OPCODE]  = ev_bad_opcode_flag;
   assign ev_level[`BIT_BAD_FETCH]   = ev_fetch;
   assign ev_level[`BIT_DEBUG_ENTRY] = ev_dbg;
   assign ev_level[`BIT_BROWNOUT]    = s_brown;

   // One-cycle pulse on the rising edge of each cause.
   wire [7:0] ev_pulse = ev_level & ~prev_ev;

   // ****************************************************************
   // APB decode
   // ****************************************************************

   wire access    = psel & penable;
   wire wr_en     = access & pwrite;
   wire rd_en     = access & ~pwrite;
   wire hit_cause = (paddr == `OFS_CAUSE_FLAGS);
   wire hit_mask  = (paddr == `OFS_IRQ_MASK);
   wire hit_opt   = (paddr == `OFS_OPTIONS);
   wire hit_ista  = (paddr == `OFS_IRQ_STATUS);
   wire mapped    = hit_cause | hit_mask | hit_opt | hit_ista;

   assign pready  = 1'b1;
   assign pslverr = access & ~mapped;

   // ****************************************************************
   // Cause flags
   // ****************************************************************

   reg  [7:0] cause_flags;
   reg  [7:0] next_cause_flags;

   // Set wins over a read clear in the same cycle.
   always @* begin
      if (ev_pulse[`BIT_POWER_ON]) begin
         next_cause_flags = 8'h00; // R2 R5
         next_cause_flags[`BIT_POWER_ON] = 1'b1; // R2
         next_cause_flags = next_cause_flags | (ev_pulse & ~8'h01); // R4
      end else begin
         if (rd_en && hit_cause) begin
            next_cause_flags = 8'h00; // R1 R5
         end else begin
            next_cause_flags = cause_flags; // R15
         end
         next_cause_flags = next_cause_flags | ev_pulse; // R3 R4 R6 R7 R8 R9 R10 R11
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause_flags <= `RST_CAUSE_FLAGS;
         prev_ev     <= 8'h00;
      end else if (clk_en) begin
         cause_flags <= next_cause_flags;
         prev_ev     <= ev_level;
      end
   end

   // ****************************************************************
   // Interrupt status (read clears) and mask
   // ****************************************************************

   reg [7:0] irq_status;

   // Sticky copy of each cause event; a read of the status clears it.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= 8'h00;
      end else if (clk_en) begin
         if (rd_en && hit_ista) begin
            irq_status <= ev_pulse;
         end else begin
            irq_status <= irq_status | ev_pulse;
         end
      end
   end

   // Mask and option writes with byte lane zero.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask <= `RST_IRQ_MASK;
         options  <= `RST_OPTIONS;
      end else if (clk_en && wr_en && pstrb[0]) begin
         if (hit_mask) begin
            irq_mask <= pwdata[7:0];
         end
         if (hit_opt) begin
            options <= {7'h00, pwdata[0]};
         end
      end
   end

   assign irq = |(irq_status & irq_mask);

   // ****************************************************************
   // Read data
   // ****************************************************************

   // Read data is registered at the access edge.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (clk_en && rd_en) begin
         case (1'b1)
            hit_cause: prdata <= {24'h00_0000, cause_flags};
            hit_mask:  prdata <= {24'h00_0000, irq_mask};
            hit_opt:   prdata <= {24'h00_0000, options};
            hit_ista:  prdata <= {24'h00_0000, irq_status};
            default:   prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ****************************************************************
   // External reset line drive
   // ****************************************************************

   reg [15:0] line_count;
   wire       internal_src = |ev_pulse[7:3] | ev_pulse[`BIT_POWER_ON];

   // Internal sources pull the line low for a fixed stretch.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_drive <= 1'b0;
         line_count <= 16'h0000;
      end else if (clk_en) begin
         if (internal_src) begin
            line_drive <= 1'b1; // R12
            line_count <= LINE_CYCLES[15:0];
         end else if (line_count > 16'h0001) begin
            line_count <= line_count - 16'h0001;
         end else begin
            line_drive <= 1'b0;
            line_count <= 16'h0000;
         end
      end
   end

   // Delayed copies of the drive that cover the synchroniser latency.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_tail <= 2'b00;
      end else if (clk_en) begin
         drive_tail <= {drive_tail[0], line_drive};
      end
   end

   assign ext_reset_n_out    = 1'b0;
   assign ext_reset_n_oe     = line_drive; // R12
   assign internal_reset_req = line_drive | s_line;

endmodule // reset_cause_status_register

// ### verif/reset_cause_checker_assertions.sv
/* Port checker for the reset-cause block.
   Assumes a bind into reset_cause_status_register, one clock pclk and reset presetn. */
`timescale 1ns/1ps
// ****************************************************************
// Checker
// ****************************************************************
module reset_cause_checker #(
   parameter LINE_CYCLES = 4
) (
   input wire        pclk,
   input wire        presetn,
   input wire        clk_en,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pslverr,
   input wire        power_on_event,
   input wire        ext_reset_n_in,
   input wire        watchdog_timeout,
   input wire        illegal_opcode,
   input wire        stop_executed,
   input wire        unmapped_access,
   input wire        opcode_fetch,
   input wire        debug_entry_request,
   input wire        brownout_event,
   input wire        ext_reset_n_out,
   input wire        ext_reset_n_oe,
   input wire        irq
);
   // Decoded accesses and a quiet state with no reset source active.
   wire       acc      = psel && penable && clk_en;
   wire       rd_cause = acc && !pwrite && paddr == 12'h000;
   wire       mapped   = paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008 || paddr == 12'h00C;
   wire       quiet    = ext_reset_n_in && !(power_on_event | watchdog_timeout | illegal_opcode | stop_executed
                         | opcode_fetch | debug_entry_request | brownout_event);
   wire       internal = watchdog_timeout | illegal_opcode | brownout_event | (unmapped_access && opcode_fetch);
   reg  [7:0] oe_cnt;
   // Counts how many cycles the reset line has been driven so far.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         oe_cnt <= 8'h00;
      else
         oe_cnt <= ext_reset_n_oe ? oe_cnt + 8'h01 : 8'h00;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_read_clears: assert property (quiet[*4] ##0 rd_cause ##1 quiet[*3] ##1 (quiet && rd_cause)
      |=> prdata == 32'h0000_0000) else $error("Cause flags survived a read.");
   a_unmapped_err: assert property (acc && !mapped |-> pslverr) else $error("No error on unmapped access.");
   a_mapped_ok: assert property (acc && mapped |-> !pslverr) else $error("Error on mapped access.");
   a_upper_zero: assert property (acc && !pwrite |=> prdata[31:8] == 24'h00_0000) else $error("Upper read bits set.");
   a_line_follows: assert property ($rose(internal) |-> ##[1:6] ext_reset_n_oe)
      else $error("Internal reset did not drive the line.");
   a_pin_low: assert property (ext_reset_n_oe |-> !ext_reset_n_out) else $error("Line driven high.");
   a_drive_length: assert property ($fell(ext_reset_n_oe) |-> oe_cnt >= LINE_CYCLES)
      else $error("Line drive too short.");
   a_data_miss: assert property ((quiet && unmapped_access && !ext_reset_n_oe)[*4] |=> !ext_reset_n_oe)
      else $error("Data miss drove the line.");
   a_mask_off: assert property (acc && pwrite && paddr == 12'h004 && pwdata[7:0] == 8'h00 |=> !irq)
      else $error("Interrupt with mask cleared.");
   c_read: cover property (rd_cause);
   c_drive: cover property ($rose(ext_reset_n_oe));
   c_irq: cover property ($rose(irq));
endmodule // reset_cause_checker

bind reset_cause_status_register reset_cause_checker #(.LINE_CYCLES(LINE_CYCLES)) reset_cause_checker_inst (.*);

// ### verif/testbench.sv
/* Self-checking bench for the reset-cause block over APB.
   Assumes the checker is bound to the design and the line is resolved here. */
`timescale 1ns/1ps
// ****************************************************************
// Testbench
// ****************************************************************
module testbench;
   reg         pclk, presetn, psel, penable, pwrite, data_miss, test_volt, err;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, rd;
   reg  [7:0]  ev, vec_lo, model, m;
   wire [31:0] prdata;
   wire        pready, pslverr, oe, irq;
   integer     failures, checks, seed, i;
   // The line is low when the bench or the design pulls it.
   reset_cause_status_register #(.LINE_CYCLES(4)) reset_cause_status_register_inst (.pclk(pclk),
      .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .power_on_event(ev[1]), .ext_reset_n_in(!(ev[2] | oe)), .watchdog_timeout(ev[3]),
      .illegal_opcode(ev[4]), .stop_executed(ev[0]), .unmapped_access(ev[5] | data_miss),
      .opcode_fetch(ev[5]), .debug_entry_request(ev[6]), .vector_high_byte_7(1'b0),
      .vector_high_byte(8'hFF), .vector_low_byte(vec_lo), .irq_at_test_voltage(test_volt),
      .brownout_event(ev[7]), .ext_reset_n_out(), .ext_reset_n_oe(oe), .internal_reset_req(), .irq(irq));
   // Power-on replaces the flags, every other source adds to them.
   function [7:0] next_flags(input [7:0] old, input [7:0] e);
      next_flags = e[1] ? e : old | e;
   endfunction
   task chk(input [95:0] nm, input [31:0] seen, input [31:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("ERROR %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // One APB transfer; the request stands until pready is seen high.
   task apb(input w, input [11:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         n = 0;
         do begin
            @(posedge pclk);
            n = n + 1;
         end while (pready !== 1'b1 && n < 50);
         if (n == 50)
            failures = failures + 1;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
         rd = prdata;
      end
   endtask
   task rdc;
      begin
         apb(1'b0, 12'h000, 32'h0000_0000);
         chk("cause", rd, {24'h00_0000, model});
         model = 8'h00;
      end
   endtask
   // Raises the chosen sources for two cycles, then lets the block settle.
   task fire(input [7:0] e_in, input [7:0] e_exp);
      begin
         @(posedge pclk);
         ev <= e_in;
         repeat (2) @(posedge pclk);
         ev <= 8'h00;
         repeat (12) @(posedge pclk);
         model = next_flags(model, e_exp);
      end
   endtask
   task end_of_test;
      begin
         $display("TB counts: %0d checks, %0d failures", checks, failures);
         if (failures == 0 && checks > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   always #2.5 pclk = ~pclk;
   // A hang counts as a failure.
   initial begin
      #100000 failures = failures + 1;
      end_of_test;
   end
   // Main sequence of tests.
   initial begin
      {pclk, presetn, psel, penable, pwrite, data_miss, test_volt} = 7'h00;
      {paddr, pwdata, ev} = 52'h0;
      vec_lo = 8'hFF;
      failures = 0;
      checks = 0;
      seed = 73823;
      model = 8'h02;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rdc;
      rdc;
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk("mask", rd, 32'h0000_0000);
      for (i = 1; i < 8; i = i + 1) begin
         fire(8'h01 << i, 8'h01 << i);
         rdc;
      end
      fire(8'h01, 8'h10);
      apb(1'b1, 12'h008, 32'h0000_0001);
      fire(8'h01, 8'h00);
      rdc;
      repeat (8) begin
         m = $random(seed) & 8'hB8;
         fire(m, m);
         fire(8'h08, 8'h08);
         rdc;
      end
      fire(8'h90, 8'h90);
      fire(8'h02, 8'h02);
      rdc;
      fire(8'h82, 8'h82);
      rdc;
      fire(8'h10, 8'h10);
      apb(1'b1, 12'h000, 32'h0000_00FF);
      rdc;
      @(posedge pclk);
      data_miss <= 1'b1;
      vec_lo <= 8'h00;
      fire(8'h40, 8'h00);
      data_miss <= 1'b0;
      vec_lo <= 8'hFF;
      test_volt <= 1'b1;
      fire(8'h40, 8'h00);
      test_volt <= 1'b0;
      rdc;
      $display("TB test flags finished");
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk("slverr", err, 32'h0000_0001);
      chk("unmapped", rd, 32'h0000_0000);
      apb(1'b0, 12'h00C, 32'h0000_0000);
      apb(1'b1, 12'h004, 32'h0000_0008);
      fire(8'h08, 8'h08);
      chk("irq on", irq, 32'h0000_0001);
      apb(1'b0, 12'h00C, 32'h0000_0000);
      chk("status", rd, 32'h0000_0008);
      chk("irq off", irq, 32'h0000_0000);
      apb(1'b1, 12'h004, 32'h0000_0000);
      fire(8'h08, 8'h08);
      chk("irq masked", irq, 32'h0000_0000);
      apb(1'b1, 12'h004, 32'h0000_0008);
      chk("irq unmask", irq, 32'h0000_0001);
      rdc;
      $display("TB test interrupt finished");
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      model = 8'h02;
      rdc;
      end_of_test;
   end
endmodule // testbench
